// file: src/srx_exec.sv
// execution unit: normalize count, push, power-off, returns, rotates,
// software break and context switch, plus a small register port
// assumes stack memory answers a read in the same cycle as o_mem_rd
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module srx_exec import srx_pkg::*; #(
  parameter int ADDR_W = 3
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_exec,
  input wire logic [7:0] i_opcode,
  input wire logic [7:0] i_byte2,
  input wire logic [15:0] i_byte34,
  input wire logic [15:0] i_op1,
  input wire logic [15:0] i_op2,
  input wire logic i_nmi,
  input wire logic i_dbg_brk_en,
  input wire logic i_break_exit,
  input wire logic [15:0] i_mem_rdata,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [15:0] o_mem_addr,
  output logic [15:0] o_mem_wdata,
  output logic [15:0] o_result,
  output logic o_result_we,
  output logic o_done,
  output logic o_busy,
  output logic o_irq_hold,
  output logic [15:0] o_sp,
  output logic [15:0] o_ip,
  output logic [15:0] o_csp,
  output logic [15:0] o_psw,
  output logic o_power_off,
  output logic o_break_mode,
  output logic o_trap,
  output logic [3:0] o_trap_vec,
  output logic o_irq
);

  if (ADDR_W < 3) begin : g_chk
    $error("srx_exec: ADDR_W must be at least 3");
  end

  function automatic logic [15:0] norm_count(input logic [15:0] w);
    logic [15:0] n;
    logic hit;
    n = 16'h0000;
    hit = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      if (!hit && w[i]) begin
        hit = 1'b1;
        n = 16'(15 - i);
      end
    end
    return n;
  endfunction : norm_count

  // returns {carry, result}
  function automatic logic [16:0] rol_calc(input logic [15:0] w,
                                           input logic [3:0] n);
    logic [15:0] r;
    logic c;
    r = w;
    c = 1'b0;
    for (int i = 0; i < 15; i++) begin
      if (4'(i) < n) begin
        c = r[15];
        r = {r[14:0], c};
      end
    end
    return {c, r};
  endfunction : rol_calc

  // returns {overflow, carry, result}
  function automatic logic [17:0] ror_calc(input logic [15:0] w,
                                           input logic [3:0] n);
    logic [15:0] r;
    logic c;
    logic v;
    r = w;
    c = 1'b0;
    v = 1'b0;
    for (int i = 0; i < 15; i++) begin
      if (4'(i) < n) begin
        v = v | c;
        c = r[0];
        r = {c, r[15:1]};
      end
    end
    return {v, c, r};
  endfunction : ror_calc

  srx_state_e state;
  logic [7:0] op_q;
  logic seg_dis;
  logic [SRX_EV_N-1:0] ev;
  logic [SRX_EV_N-1:0] status;
  logic [SRX_EV_N-1:0] mask;
  logic [3:0] rot_cnt;
  logic [16:0] rol_v;
  logic [17:0] ror_v;
  logic [4:0] push_flags;
  logic [4:0] pop_flags;
  logic bus_ok;

  // only the low nibble of a register count is used
  always_comb begin
    rot_cnt = i_op2[3:0]; // RL12
    if (i_opcode == SRX_OP_ROL_I || i_opcode == SRX_OP_ROR_I) begin
      rot_cnt = i_byte2[7:4];
    end
  end

  assign rol_v = rol_calc(i_op1, rot_cnt);
  assign ror_v = ror_calc(i_op1, rot_cnt);
  // {E, Z, 0, 0, N} for a pushed or popped word
  assign push_flags = {i_op1 == SRX_MOST_NEG, i_op1 == 16'h0000,
                       1'b0, 1'b0, i_op1[15]};
  assign pop_flags = {i_mem_rdata == SRX_MOST_NEG, i_mem_rdata == 16'h0000,
                      1'b0, 1'b0, i_mem_rdata[15]};
  // software may touch the core words only while the unit rests
  assign bus_ok = i_wr && state == S_IDLE && !i_exec;

  // sequencer: owns stack pointer, instruction words and memory strobes
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= S_IDLE;
      op_q <= 8'h00;
      o_sp <= SRX_SP_RST;
      o_ip <= SRX_WORD_RST;
      o_csp <= SRX_WORD_RST;
      o_psw <= SRX_WORD_RST;
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      o_mem_addr <= 16'h0000;
      o_mem_wdata <= 16'h0000;
      o_result <= 16'h0000;
      o_result_we <= 1'b0;
      o_done <= 1'b0;
      o_busy <= 1'b0;
      o_irq_hold <= 1'b0;
      o_power_off <= 1'b0;
      o_break_mode <= 1'b0;
      o_trap <= 1'b0;
      o_trap_vec <= 4'h0;
      ev <= '0;
    end else begin
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      o_result_we <= 1'b0;
      o_done <= 1'b0;
      o_trap <= 1'b0;
      ev <= '0;
      if (i_break_exit) begin
        o_break_mode <= 1'b0;
      end
      case (state)
        S_IDLE: begin
          if (i_exec && !o_power_off) begin
            op_q <= i_opcode;
            o_done <= 1'b1;
            ev[SRX_EV_DONE] <= 1'b1;
            case (i_opcode)
              SRX_OP_NORM: begin
                o_result <= norm_count(i_op2);
                o_result_we <= 1'b1;
                o_psw[SRX_F_E] <= 1'b0; // RL1
                o_psw[SRX_F_Z] <= i_op2 == 16'h0000; // RL1
                o_psw[SRX_F_V] <= 1'b0; // RL1
                o_psw[SRX_F_C] <= 1'b0; // RL1
                o_psw[SRX_F_N] <= 1'b0; // RL1
              end
              SRX_OP_PUSH, SRX_OP_CXT_I, SRX_OP_CXT_M: begin
                // write lands at the lowered pointer
                o_sp <= o_sp - SRX_STEP; // RL2 RL18
                o_mem_addr <= o_sp - SRX_STEP; // RL2 RL18
                o_mem_wdata <= i_op1; // RL2 RL18
                o_mem_wr <= 1'b1;
                o_result <= i_op2; // RL18
                o_done <= 1'b0;
                ev[SRX_EV_DONE] <= 1'b0;
                o_busy <= 1'b1;
                o_irq_hold <= 1'b1; // RL19
                state <= S_WRITE;
                if (i_opcode == SRX_OP_PUSH) begin
                  o_psw[SRX_F_E] <= push_flags[4]; // RL3
                  o_psw[SRX_F_Z] <= push_flags[3]; // RL3
                  o_psw[SRX_F_N] <= push_flags[0]; // RL3
                end
              end
              SRX_OP_PWR: begin
                if (i_byte2 != SRX_PWR_B2 || i_byte34 != SRX_PWR_B34) begin
                  ev[SRX_EV_BADOP] <= 1'b1;
                end else if (!i_nmi) begin
                  o_power_off <= 1'b1; // RL4 RL5
                end else begin
                  ev[SRX_EV_PWRIGN] <= 1'b1; // RL5
                end
              end
              SRX_OP_RET, SRX_OP_INTERRUPT_EXIT, SRX_OP_EXIT_AND_UNSTACK, SRX_OP_FAR_SUBROUTINE_EXIT: begin
                if ((i_opcode == SRX_OP_INTERRUPT_EXIT && i_byte2 != SRX_INTERRUPT_EXIT_B2) ||
                    ((i_opcode == SRX_OP_RET || i_opcode == SRX_OP_FAR_SUBROUTINE_EXIT) &&
                     i_byte2 != SRX_B2_ZERO)) begin
                  ev[SRX_EV_BADOP] <= 1'b1;
                end else begin
                  o_mem_rd <= 1'b1;
                  o_mem_addr <= o_sp;
                  o_done <= 1'b0;
                  ev[SRX_EV_DONE] <= 1'b0;
                  o_busy <= 1'b1;
                  o_irq_hold <= 1'b1; // RL19
                  state <= S_IP;
                end
              end
              SRX_OP_ROL_I, SRX_OP_ROL_R: begin
                o_result <= rol_v[15:0]; // RL11
                o_result_we <= 1'b1;
                o_psw[SRX_F_E] <= 1'b0; // RL13
                o_psw[SRX_F_V] <= 1'b0; // RL13
                o_psw[SRX_F_C] <= rol_v[16]; // RL13
                o_psw[SRX_F_Z] <= rol_v[15:0] == 16'h0000; // RL13
                o_psw[SRX_F_N] <= rol_v[15]; // RL13
              end
              SRX_OP_ROR_I, SRX_OP_ROR_R: begin
                o_result <= ror_v[15:0]; // RL14
                o_result_we <= 1'b1;
                o_psw[SRX_F_E] <= 1'b0; // RL15
                o_psw[SRX_F_V] <= ror_v[17]; // RL15
                o_psw[SRX_F_C] <= ror_v[16]; // RL14
                o_psw[SRX_F_Z] <= ror_v[15:0] == 16'h0000;
                o_psw[SRX_F_N] <= ror_v[15];
              end
              SRX_OP_BRK: begin
                if (i_byte2 != SRX_B2_ZERO) begin
                  ev[SRX_EV_BADOP] <= 1'b1;
                end else if (i_dbg_brk_en) begin
                  o_break_mode <= 1'b1; // RL16
                  ev[SRX_EV_BRK] <= 1'b1;
                end else begin
                  o_trap <= 1'b1; // RL17
                  o_trap_vec <= SRX_TRAP_VEC; // RL17
                  ev[SRX_EV_TRAP] <= 1'b1;
                end
              end
              default: begin
                ev[SRX_EV_BADOP] <= 1'b1;
              end
            endcase
          end else if (bus_ok) begin
            case (i_addr[2:0])
              SRX_A_SP: o_sp <= i_wdata;
              SRX_A_IP: o_ip <= i_wdata;
              SRX_A_CSP: o_csp <= i_wdata;
              SRX_A_PSW: o_psw <= i_wdata;
              default: begin
              end
            endcase
          end
        end
        S_WRITE: begin
          // register load follows the stack write
          o_result_we <= op_q != SRX_OP_PUSH; // RL18
          o_done <= 1'b1;
          ev[SRX_EV_DONE] <= 1'b1;
          o_busy <= 1'b0;
          o_irq_hold <= 1'b0;
          state <= S_IDLE;
        end
        S_IP: begin
          o_ip <= i_mem_rdata; // RL6 RL7 RL9 RL10
          o_sp <= o_sp + SRX_STEP; // RL6 RL7 RL9 RL10
          o_mem_addr <= o_sp + SRX_STEP;
          case (op_q)
            SRX_OP_INTERRUPT_EXIT: begin
              o_mem_rd <= 1'b1;
              state <= seg_dis ? S_PSW : S_CSP; // RL7
            end
            SRX_OP_FAR_SUBROUTINE_EXIT: begin
              // second word is read even when unsegmented
              o_mem_rd <= 1'b1;
              state <= S_CSP; // RL10
            end
            SRX_OP_EXIT_AND_UNSTACK: begin
              o_mem_rd <= 1'b1;
              state <= S_WORD; // RL9
            end
            default: begin
              o_done <= 1'b1;
              ev[SRX_EV_DONE] <= 1'b1;
              o_busy <= 1'b0;
              o_irq_hold <= 1'b0;
              state <= S_IDLE;
            end
          endcase
        end
        S_CSP: begin
          if (!seg_dis) begin
            o_csp <= i_mem_rdata; // RL7 RL10
          end
          o_sp <= o_sp + SRX_STEP; // RL10
          o_mem_addr <= o_sp + SRX_STEP;
          if (op_q == SRX_OP_INTERRUPT_EXIT) begin
            o_mem_rd <= 1'b1;
            state <= S_PSW;
          end else begin
            o_done <= 1'b1;
            ev[SRX_EV_DONE] <= 1'b1;
            o_busy <= 1'b0;
            o_irq_hold <= 1'b0;
            state <= S_IDLE;
          end
        end
        S_PSW: begin
          o_psw <= i_mem_rdata; // RL8
          o_sp <= o_sp + SRX_STEP; // RL7
          o_done <= 1'b1;
          ev[SRX_EV_DONE] <= 1'b1;
          o_busy <= 1'b0;
          o_irq_hold <= 1'b0;
          state <= S_IDLE;
        end
        S_WORD: begin
          o_result <= i_mem_rdata; // RL9
          o_result_we <= 1'b1;
          o_sp <= o_sp + SRX_STEP; // RL9
          o_psw[SRX_F_E] <= pop_flags[4]; // RL9
          o_psw[SRX_F_Z] <= pop_flags[3]; // RL9
          o_psw[SRX_F_N] <= pop_flags[0]; // RL9
          o_done <= 1'b1;
          ev[SRX_EV_DONE] <= 1'b1;
          o_busy <= 1'b0;
          o_irq_hold <= 1'b0;
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // control, mask and sticky status; a new event beats a clear
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      seg_dis <= 1'b0;
      mask <= '0;
      status <= '0;
    end else begin
      if (i_wr && i_addr[2:0] == SRX_A_CTRL) begin
        seg_dis <= i_wdata[SRX_CTL_SEGDIS];
      end
      if (i_wr && i_addr[2:0] == SRX_A_MASK) begin
        mask <= i_wdata[SRX_EV_N-1:0];
      end
      if (i_wr && i_addr[2:0] == SRX_A_STAT) begin
        status <= (status & ~i_wdata[SRX_EV_N-1:0]) | ev;
      end else begin
        status <= status | ev;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_irq <= 1'b0;
      o_rdata <= 16'h0000;
    end else begin
      o_irq <= |(status & mask);
      o_rdata <= 16'h0000;
      if (i_rd) begin
        case (i_addr[2:0])
          SRX_A_CTRL: o_rdata <= {15'h0, seg_dis};
          SRX_A_STAT: o_rdata <= {11'h0, status};
          SRX_A_MASK: o_rdata <= {11'h0, mask};
          SRX_A_SP: o_rdata <= o_sp;
          SRX_A_IP: o_rdata <= o_ip;
          SRX_A_CSP: o_rdata <= o_csp;
          SRX_A_PSW: o_rdata <= o_psw;
          default: o_rdata <= 16'h0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence start_op(logic [7:0] op);
    state == S_IDLE && i_exec && !o_power_off && i_opcode == op;
  endsequence
  sequence pop_one;
    o_mem_rd && o_mem_addr == o_sp;
  endsequence

  a_norm_flags: assert property (start_op(SRX_OP_NORM) |=> // RL1
    o_psw[SRX_F_Z] == ($past(i_op2) == 16'h0000) &&
    o_psw[4:0] == {1'b0, o_psw[SRX_F_Z], 3'b000})
    else $error("normalize flags wrong");
  a_push_sp_drop: assert property (start_op(SRX_OP_PUSH) |=> // RL2
    o_mem_wr && o_sp == $past(o_sp) - SRX_STEP &&
    o_mem_addr == o_sp && o_mem_wdata == $past(i_op1))
    else $error("push did not lower pointer before write");
  a_push_flags: assert property (start_op(SRX_OP_PUSH) |=> // RL3
    o_psw[SRX_F_V] == $past(o_psw[SRX_F_V]) &&
    o_psw[SRX_F_C] == $past(o_psw[SRX_F_C]) &&
    o_psw[SRX_F_N] == $past(i_op1[15]))
    else $error("push flags wrong");
  a_pwr_gated: assert property (start_op(SRX_OP_PWR) && i_nmi && // RL5
    !o_power_off |=> !o_power_off && o_psw == $past(o_psw))
    else $error("power-off acted with nmi high");
  a_ret_pop_ip: assert property (start_op(SRX_OP_RET) && // RL6
    i_byte2 == SRX_B2_ZERO |=> pop_one ##1
    (o_done && o_ip == $past(i_mem_rdata) &&
     o_sp == $past(o_sp, 2) + SRX_STEP))
    else $error("subroutine exit pop wrong");
  a_rol_carry: assert property (start_op(SRX_OP_ROL_R) && // RL13
    i_op2[3:0] == 4'h0 |=> !o_psw[SRX_F_C] && !o_psw[SRX_F_V] &&
    o_result == $past(i_op1))
    else $error("rotate left by zero changed value or carry");
  a_ror_vflag: assert property (start_op(SRX_OP_ROR_R) && // RL15
    i_op2[3:0] == 4'h2 |=> o_psw[SRX_F_V] == $past(i_op1[0]) &&
    o_psw[SRX_F_C] == $past(i_op1[1]) && !o_psw[SRX_F_E])
    else $error("rotate right overflow wrong");
  a_brk_trap: assert property (start_op(SRX_OP_BRK) && // RL17
    i_byte2 == SRX_B2_ZERO && !i_dbg_brk_en |=>
    o_trap && o_trap_vec == SRX_TRAP_VEC ##1 !o_trap)
    else $error("software break did not trap");
  a_irq_hold: assert property (state != S_IDLE |-> o_irq_hold && // RL19
    o_busy)
    else $error("stack sequence left interruptible");

endmodule : srx_exec

// file: src/srx_pkg.sv
// constants, states and register map for the stack/return/rotate execution block
// assumes one 125 MHz clock and a 16-bit word datapath
// Contract
// RL1 - normalize count: zero flag from source word; E, V, C, N cleared
// RL2 - push word: stack pointer drops by 2, then word written there
// RL3 - push word: E, Z, N from pushed value; V and C kept
// RL4 - protected power-off: power down until external reset, flags kept
// RL5 - power-off acts only while NMI pin is low, else no effect
// RL6 - subroutine exit: IP from stack, stack pointer plus 2, flags kept
// RL7 - interrupt exit: pop IP, CODE_SEGMENT_POINTER if segmentation on, then PROCESSOR_STATUS_WORD
// RL8 - after interrupt exit all five flags come from popped PROCESSOR_STATUS_WORD
// RL9 - exit-and-unstack: pop IP, then word into register, push-style flags
// RL10 - far exit: pop IP, CODE_SEGMENT_POINTER only if segmented, always add 2 twice
// RL11 - rotate left: bit 15 enters bit 0 and carry, per step
// RL12 - rotate counts 0..15; register count uses its low four bits
// RL13 - rotate left: E, V cleared; Z, N from result; C last bit out
// RL14 - rotate right: bit 0 enters bit 15 and carry, per step
// RL15 - rotate right: V ORs in carry before each step; E cleared
// RL16 - software break enters break mode when the emulator enables it
// RL17 - software break not enabled raises class A trap, vector 8
// RL18 - context switch: push old register value, then load second operand
// RL19 - multi-step stack sequences are not interrupted between steps
package srx_pkg;
  localparam int SRX_W = 16;
  localparam logic [7:0] SRX_OP_NORM = 8'h2b;
  localparam logic [7:0] SRX_OP_PUSH = 8'hec;
  localparam logic [7:0] SRX_OP_PWR = 8'h97;
  localparam logic [7:0] SRX_PWR_B2 = 8'h68;
  localparam logic [15:0] SRX_PWR_B34 = 16'h9797;
  localparam logic [7:0] SRX_OP_RET = 8'hcb;
  localparam logic [7:0] SRX_OP_INTERRUPT_EXIT = 8'hfb;
  localparam logic [7:0] SRX_INTERRUPT_EXIT_B2 = 8'h88;
  localparam logic [7:0] SRX_OP_EXIT_AND_UNSTACK = 8'heb;
  localparam logic [7:0] SRX_OP_FAR_SUBROUTINE_EXIT = 8'hdb;
  localparam logic [7:0] SRX_OP_ROL_I = 8'h1c;
  localparam logic [7:0] SRX_OP_ROL_R = 8'h0c;
  localparam logic [7:0] SRX_OP_ROR_I = 8'h3c;
  localparam logic [7:0] SRX_OP_ROR_R = 8'h2c;
  localparam logic [7:0] SRX_OP_BRK = 8'h8c;
  localparam logic [7:0] SRX_OP_CXT_I = 8'hc6;
  localparam logic [7:0] SRX_OP_CXT_M = 8'hd6;
  localparam logic [7:0] SRX_B2_ZERO = 8'h00;
  localparam logic [15:0] SRX_STEP = 16'h0002;
  localparam logic [15:0] SRX_MOST_NEG = 16'h8000;
  localparam logic [3:0] SRX_TRAP_VEC = 4'h8;
  localparam logic [15:0] SRX_SP_RST = 16'hfc00;
  localparam logic [15:0] SRX_WORD_RST = 16'h0000;
  // flag positions inside the status word
  localparam int SRX_F_N = 0;
  localparam int SRX_F_C = 1;
  localparam int SRX_F_V = 2;
  localparam int SRX_F_Z = 3;
  localparam int SRX_F_E = 4;
  // register addresses on the plain port
  localparam logic [2:0] SRX_A_CTRL = 3'h0;
  localparam logic [2:0] SRX_A_STAT = 3'h1;
  localparam logic [2:0] SRX_A_MASK = 3'h2;
  localparam logic [2:0] SRX_A_SP = 3'h3;
  localparam logic [2:0] SRX_A_IP = 3'h4;
  localparam logic [2:0] SRX_A_CSP = 3'h5;
  localparam logic [2:0] SRX_A_PSW = 3'h6;
  localparam int SRX_CTL_SEGDIS = 0;
  // sticky event bits
  localparam int SRX_EV_N = 5;
  localparam int SRX_EV_DONE = 0;
  localparam int SRX_EV_TRAP = 1;
  localparam int SRX_EV_BRK = 2;
  localparam int SRX_EV_PWRIGN = 3;
  localparam int SRX_EV_BADOP = 4;
  typedef enum logic [2:0] {
    S_IDLE, S_WRITE, S_IP, S_CSP, S_PSW, S_WORD
  } srx_state_e;
endpackage : srx_pkg

// file: tb/srx_stack_mem.sv
// behavioural stack memory facing the execution block
// assumes a read is answered in the strobe's own cycle, writes at the edge
`timescale 1ns/1ps
module srx_stack_mem (
  input wire logic i_clk,
  input wire logic i_mem_rd,
  input wire logic i_mem_wr,
  input wire logic [15:0] i_mem_addr,
  input wire logic [15:0] i_mem_wdata,
  output logic [15:0] o_mem_rdata
);
  logic [15:0] mem [0:255];
  logic [15:0] last_q;
  initial last_q = 16'h0000;
  // no pull on the data lines: idle cycles show the last word inverted
  always @(posedge i_clk) begin
    if (i_mem_wr) mem[i_mem_addr[8:1]] <= i_mem_wdata;
    if (i_mem_rd) last_q <= mem[i_mem_addr[8:1]];
  end
  assign o_mem_rdata = i_mem_rd ? mem[i_mem_addr[8:1]] : ~last_q;
endmodule : srx_stack_mem

// file: tb/test_stack_return_rotate_exec.sv
// self-checking bench for the stack/return/rotate execution block
// assumes srx_pkg, srx_exec and the stack memory model are compiled first
`timescale 1ns/1ps
module test_stack_return_rotate_exec import srx_pkg::*;;
  logic i_clk, i_reset_n, i_exec, i_nmi, i_dbg_brk_en, i_break_exit;
  logic [7:0] i_opcode, i_byte2;
  logic [15:0] i_byte34, i_op1, i_op2, i_mem_rdata, i_wdata;
  logic [2:0] i_addr;
  logic i_wr, i_rd, o_mem_rd, o_mem_wr, o_result_we, o_done, o_busy;
  logic [15:0] o_rdata, o_mem_addr, o_mem_wdata, o_result;
  logic [15:0] o_sp, o_ip, o_csp, o_psw;
  logic o_irq_hold, o_power_off, o_break_mode, o_trap, o_irq;
  logic [3:0] o_trap_vec;
  int failures, n_tests;
  logic [15:0] sp, res, rd_v;
  logic [4:0] fl;
  logic [7:0] ops [4] = '{SRX_OP_ROL_I, SRX_OP_ROL_R, SRX_OP_ROR_I,
    SRX_OP_ROR_R};

  srx_exec dut_u (.i_clk, .i_reset_n, .i_exec, .i_opcode, .i_byte2,
    .i_byte34, .i_op1, .i_op2, .i_nmi, .i_dbg_brk_en, .i_break_exit,
    .i_mem_rdata, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_mem_rd,
    .o_mem_wr, .o_mem_addr, .o_mem_wdata, .o_result, .o_result_we,
    .o_done, .o_busy, .o_irq_hold, .o_sp, .o_ip, .o_csp, .o_psw,
    .o_power_off, .o_break_mode, .o_trap, .o_trap_vec, .o_irq);
  srx_stack_mem mem_u (.i_clk(i_clk), .i_mem_rd(o_mem_rd),
    .i_mem_wr(o_mem_wr), .i_mem_addr(o_mem_addr),
    .i_mem_wdata(o_mem_wdata), .o_mem_rdata(i_mem_rdata));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task automatic summarize;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    n_tests++;
    if (e !== g) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic bus_wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [2:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    rd_v = o_rdata;
  endtask : bus_rd

  // waits on the done pulse; a missing pulse is a mismatch, not a hang
  task automatic ex(input logic [7:0] op, input logic [7:0] b2,
      input logic [15:0] a, input logic [15:0] b);
    int k;
    @(posedge i_clk);
    i_exec <= 1'b1;
    i_opcode <= op;
    i_byte2 <= b2;
    i_op1 <= a;
    i_op2 <= b;
    @(posedge i_clk);
    i_exec <= 1'b0;
    k = 0;
    @(negedge i_clk);
    while (o_done !== 1'b1 && k < 12) begin
      @(negedge i_clk);
      k++;
    end
    if (k == 12) chk("done", 16'h0001, 16'h0000);
    res = o_result;
  endtask : ex

  task automatic push(input logic [15:0] w);
    ex(SRX_OP_PUSH, 8'h21, w, 16'h0000);
    sp = sp - 16'h0002;
    chk("push sp", sp, o_sp);
    chk("push addr", sp, o_mem_addr);
  endtask : push

  // returns {overflow, carry, word}
  function automatic logic [17:0] rot(input logic [15:0] v,
      input logic [3:0] n, input logic r);
    logic c;
    logic ov;
    c = 1'b0;
    ov = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (r) begin
        ov = ov | c;
        c = v[0];
        v = {c, v[15:1]};
      end else begin
        c = v[15];
        v = {v[14:0], c};
      end
    end
    return {ov, c, v};
  endfunction : rot

  function automatic logic [4:0] pf(input logic [15:0] w,
      input logic [4:0] old);
    return {w == SRX_MOST_NEG, w == 16'h0000, old[2], old[1], w[15]};
  endfunction : pf

  function automatic logic [15:0] nrm(input logic [15:0] w);
    nrm = 16'h0000;
    if (w != 16'h0000) begin
      while (!w[15]) begin
        w = w << 1;
        nrm++;
      end
    end
  endfunction : nrm

  initial begin
    #200000;
    failures++;
    summarize();
  end

  initial begin
    logic [15:0] a, b, w;
    logic [3:0] n;
    logic [7:0] op, b2;
    logic [17:0] e;
    {i_reset_n, i_exec, i_nmi, i_dbg_brk_en, i_break_exit} = '0;
    {i_opcode, i_byte2, i_op1, i_op2, i_wdata, i_addr} = '0;
    {i_wr, i_rd} = '0;
    i_byte34 = SRX_PWR_B34;
    failures = 0;
    n_tests = 0;
    void'($urandom(95));
    repeat (5) @(posedge i_clk);
    i_reset_n <= 1'b1;
    sp = SRX_SP_RST;
    bus_rd(SRX_A_SP);
    chk("sp reset", SRX_SP_RST, rd_v);
    bus_rd(3'h7);
    chk("unmapped", 16'h0000, rd_v);
    for (int t = 0; t < 24; t++) begin
      a = $urandom;
      b = $urandom;
      n = (t < 4) ? 4'h0 : (t < 8) ? 4'hf : (t < 12) ? 4'h2 : b[3:0];
      op = ops[t % 4];
      b2 = op[4] ? {n, b[7:4]} : b[7:0];
      ex(op, b2, a, op[4] ? b : {b[15:4], n});
      e = rot(a, n, op[5]);
      fl = {1'b0, e[15:0] == 16'h0000, e[17], e[16], e[15]};
      chk("rotate word", e[15:0], res);
      chk("rotate flags", {11'h0, fl}, {11'h0, o_psw[4:0]});
      chk("rotate we", 16'h0001, {15'h0, o_result_we});
    end
    for (int t = 0; t < 4; t++) begin
      w = (t == 0) ? 16'h0000 : (16'h8000 | 16'($urandom)) >> t * 4;
      ex(SRX_OP_NORM, 8'h12, 16'hffff, w);
      chk("norm count", nrm(w), res);
      chk("norm flags", {12'h0, w == 0, 3'h0}, {11'h0, o_psw[4:0]});
    end
    bus_wr(SRX_A_PSW, 16'h0006);
    push(SRX_MOST_NEG);
    chk("push flags", 16'h0017, {11'h0, o_psw[4:0]});
    push(16'h0000);
    chk("push flags", 16'h000e, {11'h0, o_psw[4:0]});
    push(16'h1234);
    fl = o_psw[4:0];
    ex(SRX_OP_RET, 8'h01, 16'h0000, 16'h0000);
    chk("bad op sp", sp, o_sp);
    ex(SRX_OP_RET, SRX_B2_ZERO, 16'h0000, 16'h0000);
    sp = sp + 16'h0002;
    chk("ret ip", 16'h1234, o_ip);
    chk("ret sp", sp, o_sp);
    chk("ret flags", {11'h0, fl}, {11'h0, o_psw[4:0]});
    push(16'h001a);
    push(16'h0003);
    push(16'h4000);
    ex(SRX_OP_INTERRUPT_EXIT, SRX_INTERRUPT_EXIT_B2, 16'h0000, 16'h0000);
    sp = sp + 16'h0006;
    chk("interrupt_exit sp", sp, o_sp);
    chk("interrupt_exit ip csp", 16'h4003, o_ip | o_csp);
    chk("interrupt_exit flags", 16'h001a, {11'h0, o_psw[4:0]});
    bus_wr(SRX_A_CTRL, 16'h0001);
    push(16'h0005);
    push(16'h4100);
    ex(SRX_OP_INTERRUPT_EXIT, SRX_INTERRUPT_EXIT_B2, 16'h0000, 16'h0000);
    sp = sp + 16'h0004;
    chk("interrupt_exit nseg sp", sp, o_sp);
    chk("interrupt_exit nseg csp", 16'h0003, o_csp);
    chk("interrupt_exit nseg flags", 16'h0005, {11'h0, o_psw[4:0]});
    for (int t = 0; t < 2; t++) begin
      push(16'h0009);
      push(16'h4200);
      ex(SRX_OP_FAR_SUBROUTINE_EXIT, SRX_B2_ZERO, 16'h0000, 16'h0000);
      sp = sp + 16'h0004;
      chk("far_subroutine_exit sp", sp, o_sp);
      chk("far_subroutine_exit csp", (t == 0) ? 16'h0003 : 16'h0009, o_csp);
      chk("far_subroutine_exit flags", 16'h0004, {11'h0, o_psw[4:0]});
      bus_wr(SRX_A_CTRL, 16'h0000);
    end
    push(SRX_MOST_NEG);
    fl = o_psw[4:0];
    push(16'h4400);
    ex(SRX_OP_EXIT_AND_UNSTACK, 8'h21, 16'h0000, 16'h0000);
    sp = sp + 16'h0004;
    chk("exit_and_unstack ip word", 16'hc400, o_ip | res);
    chk("exit_and_unstack flags", 16'(pf(SRX_MOST_NEG, fl)), {11'h0, o_psw[4:0]});
    fl = o_psw[4:0];
    ex(SRX_OP_CXT_I, 8'h21, 16'haaaa, 16'h5555);
    sp = sp - 16'h0002;
    chk("switch load", 16'h5555, res);
    chk("switch sp", sp, o_sp);
    chk("switch we", 16'h0001, {15'h0, o_result_we});
    ex(SRX_OP_RET, SRX_B2_ZERO, 16'h0000, 16'h0000);
    sp = sp + 16'h0002;
    chk("switch pushed", 16'haaaa, o_ip);
    i_dbg_brk_en <= 1'b1;
    ex(SRX_OP_BRK, SRX_B2_ZERO, 16'h0000, 16'h0000);
    chk("break mode", 16'h0001, {15'h0, o_break_mode});
    @(posedge i_clk);
    i_break_exit <= 1'b1;
    @(posedge i_clk);
    i_break_exit <= 1'b0;
    i_dbg_brk_en <= 1'b0;
    bus_wr(SRX_A_STAT, 16'h001f);
    bus_wr(SRX_A_MASK, 16'h0002);
    chk("irq idle", 16'h0000, {15'h0, o_irq});
    ex(SRX_OP_BRK, SRX_B2_ZERO, 16'h0000, 16'h0000);
    repeat (2) @(negedge i_clk);
    chk("trap vector", {12'h0, SRX_TRAP_VEC}, {12'h0, o_trap_vec});
    chk("trap irq", {15'h0, 1'b1}, {15'h0, o_irq});
    chk("no break", 16'h0000, {15'h0, o_break_mode});
    bus_wr(SRX_A_STAT, 16'h0002);
    repeat (2) @(negedge i_clk);
    chk("irq cleared", 16'h0000, {15'h0, o_irq});
    i_nmi <= 1'b1;
    ex(SRX_OP_PWR, SRX_PWR_B2, 16'h0000, 16'h0000);
    chk("pwr refused", 16'h0000, {15'h0, o_power_off});
    bus_rd(SRX_A_STAT);
    chk("pwr ignored", 16'h0001, {15'h0, rd_v[SRX_EV_PWRIGN]});
    i_nmi <= 1'b0;
    fl = o_psw[4:0];
    ex(SRX_OP_PWR, SRX_PWR_B2, 16'h0000, 16'h0000);
    repeat (2) @(posedge i_clk);
    chk("pwr on", 16'h0001, {15'h0, o_power_off});
    chk("pwr flags", {11'h0, fl}, {11'h0, o_psw[4:0]});
    @(posedge i_clk);
    i_exec <= 1'b1;
    i_opcode <= SRX_OP_PUSH;
    @(posedge i_clk);
    i_exec <= 1'b0;
    repeat (4) @(posedge i_clk);
    chk("pwr holds", sp, o_sp);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(negedge i_clk);
    chk("pwr reset", 16'h0000, {15'h0, o_power_off});
    chk("sp reset again", SRX_SP_RST, o_sp);
    summarize();
  end
endmodule : test_stack_return_rotate_exec
